//--- verilog/tmrps_pkg.sv
package tmrps_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PRESC = 8'hd2;
   localparam logic [7:0] IDX_COUNT = 8'hd3;
   localparam logic [7:0] IDX_CTRL = 8'hd4;
   localparam logic [7:0] IDX_PORT = 8'hd5;
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_PRESC = {2'h0, IDX_PRESC, 2'h0};
   localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
   localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
   localparam logic [11:0] ADDR_PORT = {2'h0, IDX_PORT, 2'h0};
   // Control register fields
   localparam int FLAG_BIT = 7;
   localparam int IRQEN_BIT = 6;
   localparam int OUTSEL_BIT = 5;
   localparam int DATA_BIT = 4;
   localparam int RUN_BIT = 3;
   localparam int PSEL_MSB = 2;
   // Port line register fields
   localparam int PORT_DATA_BIT = 0;
   localparam int PORT_DIR_BIT = 1;
   localparam int PORT_PIN_BIT = 2;
   // Values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'hff;
   localparam logic [6:0] PRESC_RST = 7'h7f;
   localparam logic [1:0] PORT_RST = 2'h0;
   // Internal frequency divided by 12
   localparam int INT_DIV = 12;
   localparam logic [3:0] DIV_LAST = 4'(INT_DIV - 1);
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tmrps_pkg

//--- verilog/tmrps_timer.sv
`timescale 1ns/100ps
// How it works
// - Count register decrements on prescaler tap edge
// - Count reaching zero sets zero flag
// - Flag with enable raises interrupt
// - Prescaler source: clock over twelve or pin
// - Tap: input, then prescaler bit n-1
// - Run clear holds prescaler at ones, stops
// - Software prescaler load accepted while running
// - Gated mode: divided clock only while pin high
// - Event mode: pin rising edges clock prescaler
// - Output mode: flag rise moves data bit out
// - Latch transparent while flag high, else holds
// - Writing zero count or bit seven sets flag
// - Reset: count ff, prescaler 7f, control clear
// - Count write beats coinciding decrement to zero
// - Count and prescaler read back live values
// - Output select forces pin, else port line
// - Three select bits pick divide by powers two
// - Control bit layout: flag down to select
module tmrps_timer (
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic [11:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   output logic [1:0] S_AXI_BRESP_OUT,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   input wire logic [11:0] S_AXI_ARADDR_IN,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   input wire logic TIMER_PIN_IN,
   output logic TIMER_PIN_OUT,
   output logic TIMER_PIN_OE_N_OUT,
   output logic TIMER_IRQ_OUT
);

   // One-hot register decode: port, ctrl, count, presc
   function automatic logic [3:0] reg_hit(input logic [11:0] a);
      reg_hit = {a == tmrps_pkg::ADDR_PORT, a == tmrps_pkg::ADDR_CTRL,
                 a == tmrps_pkg::ADDR_COUNT, a == tmrps_pkg::ADDR_PRESC};
   endfunction : reg_hit

   // Bus state
   logic aw_full_q, aw_full_d, w_full_q, w_full_d;
   logic [11:0] aw_addr_q, aw_addr_d;
   logic [7:0] w_byte_q, w_byte_d;
   logic w_lane_q, w_lane_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic do_wr;
   logic [3:0] wr_hit, rd_hit;
   logic ps_wr, cnt_wr, ctrl_wr, port_wr;

   // Timer state
   logic [7:0] ctrl_q, ctrl_d, cnt_q, cnt_d;
   logic [6:0] ps_q, ps_d, ps_dec;
   logic [3:0] div_q, div_d;
   logic [1:0] port_q, port_d;
   logic latch_q, latch_d, irq_q, irq_d;
   logic sy1_q, sy2_q, sy3_q, lvl_q, lvl_d;
   logic div_tick, pin_rise, src_tick, cnt_tick, hw_zero;
   logic flag_set, flag_clr, run, out_sel, dout;
   logic [2:0] psel;
   logic pin_q, pin_d, oe_n_q, oe_n_d;

   assign S_AXI_AWREADY_OUT = !aw_full_q;
   assign S_AXI_WREADY_OUT = !w_full_q;
   assign S_AXI_BVALID_OUT = bvalid_q;
   assign S_AXI_BRESP_OUT = bresp_q;
   assign S_AXI_ARREADY_OUT = !rvalid_q;
   assign S_AXI_RVALID_OUT = rvalid_q;
   assign S_AXI_RDATA_OUT = rdata_q;
   assign S_AXI_RRESP_OUT = rresp_q;

   assign do_wr = aw_full_q && w_full_q && !bvalid_q;
   assign wr_hit = (do_wr && w_lane_q) ? reg_hit(aw_addr_q) : 4'h0;
   assign rd_hit = reg_hit(S_AXI_ARADDR_IN);
   assign ps_wr = wr_hit[0];
   assign cnt_wr = wr_hit[1];
   assign ctrl_wr = wr_hit[2];
   assign port_wr = wr_hit[3];

   // Bus next state
   always_comb begin
      aw_full_d = aw_full_q;
      aw_addr_d = aw_addr_q;
      w_full_d = w_full_q;
      w_byte_d = w_byte_q;
      w_lane_d = w_lane_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (S_AXI_AWVALID_IN && !aw_full_q) begin
         aw_full_d = 1'b1;
         aw_addr_d = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && !w_full_q) begin
         w_full_d = 1'b1;
         w_byte_d = S_AXI_WDATA_IN[7:0];
         w_lane_d = S_AXI_WSTRB_IN[0];
      end
      if (bvalid_q && S_AXI_BREADY_IN) begin
         bvalid_d = 1'b0;
      end
      if (do_wr) begin
         aw_full_d = 1'b0;
         w_full_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (reg_hit(aw_addr_q) == 4'h0) ? tmrps_pkg::RESP_SLVERR : tmrps_pkg::RESP_OKAY;
      end
      if (rvalid_q && S_AXI_RREADY_IN) begin
         rvalid_d = 1'b0;
      end
      if (S_AXI_ARVALID_IN && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = (rd_hit == 4'h0) ? tmrps_pkg::RESP_SLVERR : tmrps_pkg::RESP_OKAY;
         rdata_d = 32'h0;
         unique case (1'b1)
            rd_hit[0]: rdata_d[6:0] = ps_q;
            rd_hit[1]: rdata_d[7:0] = cnt_q;
            rd_hit[2]: rdata_d[7:0] = ctrl_q;
            rd_hit[3]: rdata_d[2:0] = {lvl_q, port_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 12'h0;
         w_full_q <= 1'b0;
         w_byte_q <= 8'h0;
         w_lane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
         rvalid_q <= 1'b0;
         rresp_q <= 2'h0;
         rdata_q <= 32'h0;
      end else begin
         aw_full_q <= aw_full_d;
         aw_addr_q <= aw_addr_d;
         w_full_q <= w_full_d;
         w_byte_q <= w_byte_d;
         w_lane_q <= w_lane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // Control fields
   assign run = ctrl_q[tmrps_pkg::RUN_BIT];
   assign out_sel = ctrl_q[tmrps_pkg::OUTSEL_BIT];
   assign dout = ctrl_q[tmrps_pkg::DATA_BIT];
   assign psel = ctrl_q[tmrps_pkg::PSEL_MSB:0];

   // Pin edge seen once second and third stages agree
   assign pin_rise = (sy2_q == sy3_q) && sy3_q && !lvl_q;
   assign div_tick = div_q == tmrps_pkg::DIV_LAST;
   assign ps_dec = ps_q - 7'h1;

   // Timer next state
   always_comb begin
      lvl_d = (sy2_q == sy3_q) ? sy3_q : lvl_q;
      div_d = div_tick ? 4'h0 : div_q + 4'h1;
      if (out_sel) begin
         src_tick = div_tick;
      end else if (dout) begin
         src_tick = div_tick && lvl_q;
      end else begin
         src_tick = pin_rise;
      end
      // Counter clock from the selected tap rising edge
      if (psel == 3'h0) begin
         cnt_tick = run && src_tick && !ps_wr;
      end else begin
         cnt_tick = run && src_tick && !ps_wr && !ps_q[psel - 3'h1] && ps_dec[psel - 3'h1];
      end
      if (!run) begin
         ps_d = tmrps_pkg::PRESC_RST;
      end else if (ps_wr) begin
         ps_d = w_byte_q[6:0];
      end else if (src_tick) begin
         ps_d = ps_dec;
      end else begin
         ps_d = ps_q;
      end
      hw_zero = 1'b0;
      if (cnt_wr) begin
         cnt_d = w_byte_q;
      end else if (cnt_tick) begin
         cnt_d = cnt_q - 8'h1;
         hw_zero = cnt_q == 8'h01;
      end else begin
         cnt_d = cnt_q;
      end
      flag_set = hw_zero || (cnt_wr && w_byte_q == 8'h00) || (ctrl_wr && w_byte_q[7]);
      flag_clr = ctrl_wr && !w_byte_q[7];
      ctrl_d = ctrl_q;
      if (ctrl_wr) begin
         ctrl_d[6:0] = w_byte_q[6:0];
      end
      ctrl_d[tmrps_pkg::FLAG_BIT] = flag_set || (ctrl_q[tmrps_pkg::FLAG_BIT] && !flag_clr);
      irq_d = ctrl_d[tmrps_pkg::FLAG_BIT] && ctrl_d[tmrps_pkg::IRQEN_BIT];
      latch_d = ctrl_q[tmrps_pkg::FLAG_BIT] ? dout : latch_q;
      port_d = port_wr ? w_byte_q[1:0] : port_q;
      pin_d = ctrl_d[tmrps_pkg::OUTSEL_BIT] ? latch_d : port_d[tmrps_pkg::PORT_DATA_BIT];
      oe_n_d = ctrl_d[tmrps_pkg::OUTSEL_BIT] ? 1'b0 : !port_d[tmrps_pkg::PORT_DIR_BIT];
   end

   always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         ctrl_q <= tmrps_pkg::CTRL_RST;
         cnt_q <= tmrps_pkg::COUNT_RST;
         ps_q <= tmrps_pkg::PRESC_RST;
         div_q <= 4'h0;
         port_q <= tmrps_pkg::PORT_RST;
         latch_q <= 1'b0;
         irq_q <= 1'b0;
         sy1_q <= 1'b0;
         sy2_q <= 1'b0;
         sy3_q <= 1'b0;
         lvl_q <= 1'b0;
         pin_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         cnt_q <= cnt_d;
         ps_q <= ps_d;
         div_q <= div_d;
         port_q <= port_d;
         latch_q <= latch_d;
         irq_q <= irq_d;
         sy1_q <= TIMER_PIN_IN;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         lvl_q <= lvl_d;
         pin_q <= pin_d;
         oe_n_q <= oe_n_d;
      end
   end

   // Pin forced to timer output, else ordinary port line
   assign TIMER_PIN_OUT = pin_q;
   assign TIMER_PIN_OE_N_OUT = oe_n_q;
   assign TIMER_IRQ_OUT = irq_q;

   // Checks
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!NRST_IN);

   sequence s_flag_rise;
      out_sel && !ctrl_q[tmrps_pkg::FLAG_BIT] ##1 ctrl_q[tmrps_pkg::FLAG_BIT] && out_sel && !ctrl_wr;
   endsequence

   sequence s_last_tick;
      cnt_tick && !cnt_wr && cnt_q == 8'h01 && ctrl_q[tmrps_pkg::IRQEN_BIT] && !ctrl_wr;
   endsequence

   sequence s_count_ask;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN == tmrps_pkg::ADDR_COUNT;
   endsequence

   count_dec_a: assert property (cnt_tick && !cnt_wr |=> cnt_q == $past(cnt_q) - 8'h1)
      else $error("count did not step down on tap edge");
   zero_flag_a: assert property (cnt_tick && !cnt_wr && cnt_q == 8'h01 |=> ctrl_q[7])
      else $error("zero flag not set at count zero");
   irq_raise_a: assert property (s_last_tick |=> TIMER_IRQ_OUT && cnt_q == 8'h00)
      else $error("interrupt missing after count zero");
   presc_hold_a: assert property (!run |=> ps_q == 7'h7f && $stable(cnt_q) || $past(cnt_wr))
      else $error("prescaler not held while stopped");
   gate_stop_a: assert property (run && !out_sel && dout && !lvl_q && !ps_wr |=> $stable(ps_q))
      else $error("gated prescaler moved with pin low");
   div_rate_a: assert property (div_tick |=> !div_tick [*8] ##1 !div_tick [*3] ##1 div_tick)
      else $error("internal tick not every twelve clocks");
   out_latch_a: assert property (s_flag_rise |=> TIMER_PIN_OUT == $past(dout) && !TIMER_PIN_OE_N_OUT)
      else $error("data bit not moved to pin on flag rise");
   latch_hold_a: assert property (out_sel && !ctrl_q[7] && $past(!ctrl_q[7]) && $stable(out_sel)
      |-> $stable(TIMER_PIN_OUT))
      else $error("pin changed while flag low");
   wr_wins_a: assert property (cnt_wr && w_byte_q != 8'h00 && !ctrl_q[7] && !ctrl_wr |=> !ctrl_q[7])
      else $error("flag set despite count write");
   sw_zero_a: assert property (cnt_wr && w_byte_q == 8'h00 |=> ctrl_q[7] && cnt_q == 8'h00)
      else $error("writing zero count did not set flag");
   pin_force_a: assert property (out_sel |-> !TIMER_PIN_OE_N_OUT)
      else $error("pin not driven in output mode");

   // Prescaler source and tap checks
   pin_rise_a: assert property (run && !out_sel && !dout && pin_rise && !ps_wr
      |=> ps_q == $past(ps_q) - 7'h1)
      else $error("event prescaler missed pin edge");
   event_still_a: assert property (run && !out_sel && !dout && !pin_rise && !ps_wr |=> $stable(ps_q))
      else $error("event prescaler moved without edge");
   out_src_a: assert property (run && out_sel && div_tick && !ps_wr |=> ps_q == $past(ps_q) - 7'h1)
      else $error("output mode prescaler missed tick");
   out_still_a: assert property (run && out_sel && !div_tick && !ps_wr |=> $stable(ps_q))
      else $error("output mode prescaler moved off tick");
   gate_run_a: assert property (run && !out_sel && dout && lvl_q && div_tick && !ps_wr
      |=> ps_q == $past(ps_q) - 7'h1)
      else $error("gated prescaler idle with pin high");
   presc_load_a: assert property (run && ps_wr |=> ps_q == $past(w_byte_q[6:0]))
      else $error("prescaler load not taken");
   div_one_a: assert property (run && psel == 3'h0 && src_tick && !ps_wr && !cnt_wr
      |=> cnt_q == $past(cnt_q) - 8'h1)
      else $error("divide by one missed a source tick");
   tap_quiet_a: assert property (psel == 3'h1 && src_tick && ps_q[0] && !cnt_wr |=> $stable(cnt_q))
      else $error("count stepped without tap rising");

   // Count, flag and pin checks
   cnt_hold_a: assert property (!cnt_tick && !cnt_wr |=> $stable(cnt_q))
      else $error("count moved without tap edge");
   stop_cnt_a: assert property (!run && !cnt_wr |=> $stable(cnt_q))
      else $error("count moved while stopped");
   wrap_a: assert property (cnt_tick && !cnt_wr && cnt_q == 8'h00 |=> cnt_q == 8'hff)
      else $error("count did not wrap to ff");
   set_wins_a: assert property (hw_zero && ctrl_wr && !w_byte_q[7] |=> ctrl_q[7])
      else $error("flag clear beat count zero");
   sw_flag_a: assert property (ctrl_wr && w_byte_q[7] |=> ctrl_q[7])
      else $error("control bit seven write did not set flag");
   clear_flag_a: assert property (ctrl_wr && !w_byte_q[7] && !hw_zero |=> !ctrl_q[7])
      else $error("flag not cleared by control write");
   irq_level_a: assert property (TIMER_IRQ_OUT == (ctrl_q[tmrps_pkg::FLAG_BIT] && ctrl_q[tmrps_pkg::IRQEN_BIT]))
      else $error("interrupt level differs from flag and enable");
   latch_open_a: assert property (out_sel && ctrl_q[7] && !ctrl_wr |=> TIMER_PIN_OUT == $past(dout))
      else $error("latch not transparent while flag high");
   port_line_a: assert property (!out_sel
      |-> TIMER_PIN_OUT == port_q[tmrps_pkg::PORT_DATA_BIT] && TIMER_PIN_OE_N_OUT == !port_q[tmrps_pkg::PORT_DIR_BIT])
      else $error("pin not following port line");
   count_read_a: assert property (s_count_ask |=> S_AXI_RDATA_OUT == {24'h0, $past(cnt_q)})
      else $error("count read back wrong value");

endmodule : tmrps_timer

//--- tb/tmrps_pin_src.sv
`timescale 1ns/100ps
module tmrps_pin_src (
   input wire logic clk_in,
   input wire logic pin_drv_in,
   input wire logic oe_n_in,
   output logic pin_lvl_out
);
   logic src_q = 1'b0;
   // Wire level: timer drives when enable low
   assign pin_lvl_out = oe_n_in ? src_q : pin_drv_in;
   // Clean pulses, 5 clocks high and low
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (5) @(posedge clk_in);
         src_q <= 1'b1;
         repeat (5) @(posedge clk_in);
         src_q <= 1'b0;
      end
   endtask : pulse
   // Level held for gating
   task automatic hold(input logic v);
      @(posedge clk_in);
      src_q <= v;
   endtask : hold
endmodule : tmrps_pin_src

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0, nrst = 1'b0;
   logic [11:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic awready, wready, bvalid, arready, rvalid, pin_out, oe_n, irq, pin_lvl;
   logic [1:0] bresp, rresp;
   logic [31:0] d;
   logic [1:0] r;
   int err_count = 0, total_checks = 0;
   tmrps_timer uut (.CLOCK_IN(clk), .NRST_IN(nrst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
      .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
      .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
      .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
      .TIMER_PIN_IN(pin_lvl), .TIMER_PIN_OUT(pin_out), .TIMER_PIN_OE_N_OUT(oe_n), .TIMER_IRQ_OUT(irq));
   tmrps_pin_src src (.clk_in(clk), .pin_drv_in(pin_out), .oe_n_in(oe_n), .pin_lvl_out(pin_lvl));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic final_report;
      if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic hang;
      err_count++;
      final_report();
   endtask : hang
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 50) hang();
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 50) hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic t_reset;
      rd(tmrps_pkg::ADDR_PRESC);
      chk(d, 32'h7f);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(d, 32'hff);
      rd(tmrps_pkg::ADDR_CTRL);
      chk(d, 32'h00);
      rd(12'h010);
      chk(d, 32'h0);
      chk(32'(r), 32'(tmrps_pkg::RESP_SLVERR));
      wr(12'h010, 8'h55);
      chk(32'(r), 32'(tmrps_pkg::RESP_SLVERR));
   endtask : t_reset
   task automatic t_stopped;
      wr(tmrps_pkg::ADDR_PRESC, 8'h05);
      repeat (40) @(posedge clk);
      rd(tmrps_pkg::ADDR_PRESC);
      chk(d, 32'h7f);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(d, 32'hff);
   endtask : t_stopped
   task automatic t_output;
      int n;
      wr(tmrps_pkg::ADDR_COUNT, 8'h02);
      wr(tmrps_pkg::ADDR_CTRL, 8'h78);
      for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk);
      if (n == 100) hang();
      chk(32'(irq), 32'h1);
      repeat (2) @(posedge clk);
      chk(32'({oe_n, pin_lvl}), 32'h1);
      rd(tmrps_pkg::ADDR_CTRL);
      chk(d, 32'hf8);
      repeat (8) @(posedge clk);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(d, 32'hff);
      wr(tmrps_pkg::ADDR_CTRL, 8'h68);
      repeat (2) @(posedge clk);
      chk(32'({irq, pin_lvl}), 32'h1);
      wr(tmrps_pkg::ADDR_CTRL, 8'he8);
      repeat (2) @(posedge clk);
      chk(32'({irq, pin_lvl}), 32'h2);
      wr(tmrps_pkg::ADDR_CTRL, 8'h00);
      wr(tmrps_pkg::ADDR_COUNT, 8'h00);
      rd(tmrps_pkg::ADDR_CTRL);
      chk(d, 32'h80);
   endtask : t_output
   task automatic t_event;
      wr(tmrps_pkg::ADDR_CTRL, 8'h00);
      wr(tmrps_pkg::ADDR_COUNT, 8'h02);
      wr(tmrps_pkg::ADDR_CTRL, 8'h09);
      src.pulse(3);
      repeat (6) @(posedge clk);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(d, 32'h01);
      rd(tmrps_pkg::ADDR_PRESC);
      chk(d, 32'h7c);
      src.pulse(1);
      repeat (6) @(posedge clk);
      rd(tmrps_pkg::ADDR_CTRL);
      chk(d, 32'h89);
   endtask : t_event
   task automatic t_gated;
      wr(tmrps_pkg::ADDR_CTRL, 8'h00);
      wr(tmrps_pkg::ADDR_PORT, 8'h00);
      wr(tmrps_pkg::ADDR_COUNT, 8'h50);
      src.hold(1'b0);
      wr(tmrps_pkg::ADDR_CTRL, 8'h1a);
      wr(tmrps_pkg::ADDR_PRESC, 8'h10);
      repeat (40) @(posedge clk);
      rd(tmrps_pkg::ADDR_PRESC);
      chk(d, 32'h10);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(d, 32'h50);
      src.hold(1'b1);
      repeat (54) @(posedge clk);
      rd(tmrps_pkg::ADDR_COUNT);
      chk(32'({oe_n, d < 32'h50}), 32'h3);
      wr(tmrps_pkg::ADDR_PORT, 8'h02);
      repeat (4) @(posedge clk);
      chk(32'({oe_n, pin_lvl}), 32'h0);
      rd(tmrps_pkg::ADDR_PORT);
      chk(d, 32'h2);
   endtask : t_gated
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_stopped();
      t_output();
      t_event();
      t_gated();
      final_report();
   end
endmodule : tb
